// *** rtl/ctl_pkg.sv ***
package ctl_pkg;

  localparam int CTL_ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] CTL_OFS_STATUS = 8'h00;
  localparam logic [7:0] CTL_OFS_CLEAR = 8'h04;
  localparam logic [7:0] CTL_OFS_FILTER = 8'h08;
  localparam logic [7:0] CTL_OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] CTL_OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] CTL_OFS_IRQ_ENABLE = 8'h14;

  // status register bits
  localparam int CTL_STS_LATCH_BIT = 0;
  localparam int CTL_STS_FILTER_BIT = 1;
  localparam int CTL_STS_RAW_BIT = 2;
  localparam int CTL_STS_RAMP_HALT_BIT = 3;

  // clear register bits
  localparam int CTL_CLR_LATCH_BIT = 0;

  // filter control layout
  localparam int CTL_FIL_DIV_LSB = 0;
  localparam int CTL_FIL_CNT_LSB = 16;
  localparam int CTL_FIL_INIT_BIT = 31;

  // interrupt bits
  localparam int CTL_IRQ_TRIP_BIT = 0;
  localparam int CTL_IRQ_FILTER_HIGH_BIT = 1;
  localparam int CTL_IRQ_W = 2;

  // reset values
  localparam logic [9:0] CTL_DIV_RESET = 10'h000;
  localparam logic [4:0] CTL_CNT_RESET = 5'h00;
  localparam logic [CTL_IRQ_W-1:0] CTL_IRQ_EN_RESET = 2'h0;

  localparam logic [1:0] CTL_HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic sel;
    logic [1:0] trans;
    logic [CTL_ADDR_W-1:0] addr;
    logic write;
    logic [2:0] size;
    logic ready;
  } ctl_ahb_req_t;

  typedef struct packed {
    logic [9:0] divider;
    logic [4:0] agree_count;
    logic reinit;
  } ctl_filter_cfg_t;

endpackage

// *** rtl/ctl_trip_filter.sv ***
`timescale 1ns/1ps
module ctl_trip_filter
  import ctl_pkg::*;
#(
  parameter int DIV_W = 10,
  parameter int CNT_W = 5
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic comp_in,
  input wire logic reinit,
  input wire logic [DIV_W-1:0] divider,
  input wire logic [CNT_W-1:0] agree_count,
  output logic filter_out
);
  if (DIV_W < 1 || CNT_W < 1)
  begin : gen_width_check
    $error("ctl_trip_filter: widths must be positive");
  end

  logic [DIV_W-1:0] div_cnt;
  logic [CNT_W-1:0] agree_cnt;

  // sample strobe once per (divider + 1) cycles; compare with >= so a
  // divider lowered below the running count cannot stall until wrap
  wire sample_tick = (div_cnt >= divider); // [RULE11]
  // input arrives digitised; an extra flop here would add a cycle
  wire differs = (comp_in != filter_out); // [RULE2]
  wire agree_done = differs && (agree_cnt >= agree_count);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_cnt <= '0;
    else if (reinit || sample_tick)
      div_cnt <= '0; // [RULE7]
    else
      div_cnt <= div_cnt + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      agree_cnt <= '0;
    else if (reinit)
      agree_cnt <= '0; // [RULE7]
    else if (sample_tick)
      agree_cnt <= (differs && !agree_done) ? agree_cnt + 1'b1 : '0; // [RULE11]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      filter_out <= 1'b0;
    else if (reinit)
      filter_out <= 1'b0; // [RULE7]
    else if (sample_tick && agree_done)
      filter_out <= comp_in; // [RULE11] [RULE3] [RULE2]
  end
endmodule

// *** rtl/ctl_trip_latch.sv ***
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
// Contract
// [RULE1] trip latch holds until software clear or sync pulse
// [RULE2] latch set only from digitised, filtered comparator output
// [RULE3] worst latency is 1 + prescale + threshold times prescale
// [RULE4] after clear, filter pipeline may show stale data for latency count
// [RULE5] filter high at clear sets latch again next cycle
// [RULE6] filter output readable in status register
// [RULE7] filter reinit flushes sample history
// [RULE8] software waits for filter low before clearing latch
// [RULE9] system removes trip at least latency before sync pulse
// [RULE10] high-side flag set by trip and halts ramp decrement
// [RULE11] filter samples once per prescale, switches after agree count
module ctl_trip_latch
  import ctl_pkg::*;
#(
  parameter int DIV_W = 10,
  parameter int CNT_W = 5
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [CTL_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic comp_in,
  input wire logic pwm_period_sync_pulse,
  output logic trip_hold_latch,
  output logic high_side_trip_flag,
  output logic ramp_halt,
  output logic irq
);
  // configuration carrier holds 10 divider bits and 5 count bits
  if (DIV_W < 1 || DIV_W > 10 || CNT_W < 1 || CNT_W > 5)
  begin : gen_width_check
    $error("ctl_trip_latch: filter widths do not fit the fields");
  end

  ctl_ahb_req_t req;
  ctl_filter_cfg_t cfg;
  logic wr_pend;
  logic [CTL_ADDR_W-1:0] wr_addr;
  logic filter_out;
  logic filter_prev;
  logic [CTL_IRQ_W-1:0] irq_status;
  logic [CTL_IRQ_W-1:0] irq_enable;
  logic [DIV_W-1:0] divider;
  logic [CNT_W-1:0] agree_count;

  assign req = '{sel: hsel, trans: htrans, addr: haddr, write: hwrite,
                 size: hsize, ready: hready};

  // address phase decode
  wire addr_phase = req.sel && req.ready && (req.trans == CTL_HTRANS_NONSEQ);
  wire rd_phase = addr_phase && !req.write;
  wire wr_phase = addr_phase && req.write;

  // data phase write strobes
  wire wr_clear = wr_pend && (wr_addr == CTL_OFS_CLEAR);
  wire wr_filter = wr_pend && (wr_addr == CTL_OFS_FILTER);
  wire wr_irq_clr = wr_pend && (wr_addr == CTL_OFS_IRQ_CLEAR);
  wire wr_irq_en = wr_pend && (wr_addr == CTL_OFS_IRQ_ENABLE);

  wire sw_clear = wr_clear && hwdata[CTL_CLR_LATCH_BIT];
  wire latch_clear = sw_clear || pwm_period_sync_pulse;
  wire filter_rise = filter_out && !filter_prev;

  assign cfg.divider = wr_filter ? hwdata[CTL_FIL_DIV_LSB +: 10] : 10'h000;
  assign cfg.agree_count = wr_filter ? hwdata[CTL_FIL_CNT_LSB +: 5] : 5'h00;
  assign cfg.reinit = wr_filter && hwdata[CTL_FIL_INIT_BIT];

  // events: new trip, filter going high
  wire [CTL_IRQ_W-1:0] irq_event = {filter_rise,
                                    filter_out && !trip_hold_latch};
  wire [CTL_IRQ_W-1:0] irq_clr_bits =
    wr_irq_clr ? hwdata[CTL_IRQ_W-1:0] : '0;
  wire [CTL_IRQ_W-1:0] next_irq_status =
    (irq_status & ~irq_clr_bits) | irq_event;

  wire [31:0] status_word = {28'h0000000, ramp_halt, comp_in, filter_out,
                             trip_hold_latch}; // [RULE6]
  wire [31:0] filter_word = {{(16-CNT_W){1'b0}}, agree_count,
                             {(16-DIV_W){1'b0}}, divider};
  wire [31:0] next_hrdata =
    !rd_phase ? 32'h00000000 :
    (req.addr == CTL_OFS_STATUS) ? status_word :
    (req.addr == CTL_OFS_FILTER) ? filter_word :
    (req.addr == CTL_OFS_IRQ_STATUS) ? {30'h00000000, irq_status} :
    (req.addr == CTL_OFS_IRQ_ENABLE) ? {30'h00000000, irq_enable} :
    32'h00000000;

  ctl_trip_filter #(
    .DIV_W(DIV_W),
    .CNT_W(CNT_W)
  ) u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .comp_in(comp_in),
    .reinit(cfg.reinit),
    .divider(divider),
    .agree_count(agree_count),
    .filter_out(filter_out)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pend <= wr_phase;
      wr_addr <= req.addr;
      hrdata <= next_hrdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      divider <= CTL_DIV_RESET[DIV_W-1:0];
      agree_count <= CTL_CNT_RESET[CNT_W-1:0];
    end
    else if (wr_filter)
    begin
      divider <= cfg.divider[DIV_W-1:0];
      agree_count <= cfg.agree_count[CNT_W-1:0];
    end
  end

  // clear takes this edge; a filter still high re-sets on the next
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      trip_hold_latch <= 1'b0;
    else if (latch_clear)
      trip_hold_latch <= 1'b0; // [RULE1] [RULE5] [RULE4]
    else if (filter_out)
      trip_hold_latch <= 1'b1; // [RULE2] [RULE5]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      high_side_trip_flag <= 1'b0;
      ramp_halt <= 1'b0;
    end
    else
    begin
      high_side_trip_flag <= !latch_clear &&
                             (filter_out || trip_hold_latch); // [RULE10]
      // ramp stops while flag stands; sync restarts it
      ramp_halt <= !latch_clear && (filter_out || trip_hold_latch); // [RULE10]
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filter_prev <= 1'b0;
      irq_status <= '0;
      irq_enable <= CTL_IRQ_EN_RESET;
      irq <= 1'b0;
    end
    else
    begin
      filter_prev <= filter_out;
      irq_status <= next_irq_status;
      if (wr_irq_en)
        irq_enable <= hwdata[CTL_IRQ_W-1:0];
      irq <= |(next_irq_status & (wr_irq_en ? hwdata[CTL_IRQ_W-1:0]
                                            : irq_enable));
    end
  end
endmodule

// *** testbench/ctl_comp_source.sv ***
`timescale 1ns/1ps
module ctl_comp_source
(
  input logic hclk,
  input logic hresetn,
  input logic trip_req,
  input logic sync_req,
  output logic comp_in,
  output logic pwm_period_sync_pulse
);
  // comparator level arrives digitised, one flop late
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      comp_in <= 1'b0;
      pwm_period_sync_pulse <= 1'b0;
    end
    else
    begin
      comp_in <= trip_req;
      pwm_period_sync_pulse <= sync_req;
    end
  end
endmodule

// *** testbench/ctl_trip_monitor.sv ***
`timescale 1ns/1ps
module ctl_trip_monitor
  import ctl_pkg::*;
(
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [CTL_ADDR_W-1:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic [31:0] hwdata,
  input logic [31:0] hrdata,
  input logic comp_in,
  input logic pwm_period_sync_pulse,
  input logic trip_hold_latch,
  input logic high_side_trip_flag,
  input logic ramp_halt,
  input logic irq
);
  logic rd_q;
  logic st_q;
  logic clr_q;
  wire take = hsel && hready && htrans == CTL_HTRANS_NONSEQ;
  wire sw_clr = clr_q && hwdata[CTL_CLR_LATCH_BIT];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_q <= 1'b0;
      st_q <= 1'b0;
      clr_q <= 1'b0;
    end
    else
    begin
      rd_q <= take && !hwrite;
      st_q <= take && !hwrite && haddr == CTL_OFS_STATUS;
      clr_q <= take && hwrite && haddr == CTL_OFS_CLEAR;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  latch_hold_a: assert property (trip_hold_latch && !sw_clr &&
    !pwm_period_sync_pulse |=> trip_hold_latch) else $error("latch lost");
  sync_clear_a: assert property (pwm_period_sync_pulse |=>
    !trip_hold_latch) else $error("sync did not clear");
  sw_clear_a: assert property (sw_clr |=> !trip_hold_latch)
    else $error("write did not clear");
  flag_rise_a: assert property ($rose(trip_hold_latch) |->
    ##[0:1] high_side_trip_flag) else $error("flag missing");
  ramp_halt_a: assert property (trip_hold_latch |-> ramp_halt)
    else $error("ramp runs while tripped");
  clear_release_a: assert property ((sw_clr ||
    pwm_period_sync_pulse) |=> !high_side_trip_flag && !ramp_halt)
    else $error("flag kept after clear");
  status_latch_a: assert property (st_q |->
    hrdata[CTL_STS_LATCH_BIT] == $past(trip_hold_latch))
    else $error("status latch bit");
  status_raw_a: assert property (st_q |->
    hrdata[CTL_STS_RAW_BIT] == $past(comp_in))
    else $error("status raw bit");
  status_halt_a: assert property (st_q |->
    hrdata[CTL_STS_RAMP_HALT_BIT] == $past(ramp_halt))
    else $error("status halt bit");
  idle_zero_a: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside read");
  cover property ($rose(trip_hold_latch));
  cover property (pwm_period_sync_pulse && trip_hold_latch);
  cover property ($rose(irq));
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import ctl_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, trip_req, sync_req;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic hreadyout, hresp, comp_in, pwm_period_sync_pulse;
  logic trip_hold_latch, high_side_trip_flag, ramp_halt, irq;
  int err_total, samples_checked, n;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} ctl_row_t;
  ctl_row_t rows [6] = '{'{CTL_OFS_FILTER, 32'h801F03FF, 32'h001F03FF},
    '{CTL_OFS_IRQ_ENABLE, 32'h3, 32'h3}, '{CTL_OFS_STATUS, '1, 32'h0},
    '{8'h20, '1, 32'h0}, '{CTL_OFS_IRQ_STATUS, 32'hFF, 32'h0},
    '{CTL_OFS_FILTER, 32'h00020003, 32'h00020003}};
  assign hready = hreadyout;
  ctl_trip_latch ctl_trip_latch_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .comp_in(comp_in),
    .pwm_period_sync_pulse(pwm_period_sync_pulse),
    .trip_hold_latch(trip_hold_latch),
    .high_side_trip_flag(high_side_trip_flag),
    .ramp_halt(ramp_halt),
    .irq(irq)
  );
  ctl_comp_source ctl_comp_source_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .trip_req(trip_req),
    .sync_req(sync_req),
    .comp_in(comp_in),
    .pwm_period_sync_pulse(pwm_period_sync_pulse)
  );
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= CTL_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task tick(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask
  initial
  begin
    #300000;
    err_total++;
    end_of_test;
  end
  initial
  begin
    {hresetn, hsel, hwrite, trip_req, sync_req, haddr, htrans} = '0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tick(4);
    chk({irq, ramp_halt, high_side_trip_flag, trip_hold_latch, hresp,
      hreadyout}, 32'h1);
    hresetn = 1'b1;
    foreach (rows[i])
    begin
      ahb(1'b1, rows[i].a, rows[i].w);
      ahb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    trip_req <= 1'b1;
    do tick(1); while (comp_in !== 1'b1);
    n = 0;
    while (trip_hold_latch !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    // divider 3 is a period of 4, count 2: worst 1 + 4 + 2 * 4 cycles
    chk(n >= 8 && n <= 13, 32'h1);
    ahb(1'b0, CTL_OFS_STATUS, 32'h0);
    chk(rd[3:0], 4'hF);
    chk(irq, 32'h1);
    ahb(1'b1, CTL_OFS_CLEAR, 32'h1);
    #1;
    chk(trip_hold_latch, 32'h0);
    tick(1);
    chk(trip_hold_latch, 32'h1);
    trip_req <= 1'b0;
    n = 0;
    do
    begin
      ahb(1'b0, CTL_OFS_STATUS, 32'h0);
      n++;
    end
    while (rd[1] !== 1'b0 && n < 50);
    chk(n < 50, 32'h1);
    chk(trip_hold_latch, 32'h1);
    ahb(1'b1, CTL_OFS_CLEAR, 32'h1);
    tick(3);
    chk(trip_hold_latch, 32'h0);
    ahb(1'b1, CTL_OFS_IRQ_ENABLE, 32'h0);
    tick(1);
    chk(irq, 32'h0);
    ahb(1'b1, CTL_OFS_IRQ_ENABLE, 32'h3);
    tick(1);
    chk(irq, 32'h1);
    ahb(1'b1, CTL_OFS_IRQ_CLEAR, 32'h3);
    tick(1);
    chk(irq, 32'h0);
    ahb(1'b0, CTL_OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0);
    trip_req <= 1'b1;
    tick(20);
    trip_req <= 1'b0;
    tick(40);
    chk(trip_hold_latch, 32'h1);
    sync_req <= 1'b1;
    tick(1);
    sync_req <= 1'b0;
    tick(3);
    chk({ramp_halt, trip_hold_latch}, 32'h0);
    trip_req <= 1'b1;
    tick(20);
    trip_req <= 1'b0;
    tick(2);
    ahb(1'b1, CTL_OFS_FILTER, 32'h80020003);
    ahb(1'b0, CTL_OFS_STATUS, 32'h0);
    chk(rd[1:0], 2'h1);
    ahb(1'b1, CTL_OFS_CLEAR, 32'h1);
    tick(2);
    chk(trip_hold_latch, 32'h0);
    // reset in mid-run with the latch set clears state and config
    trip_req <= 1'b1;
    tick(20);
    chk(trip_hold_latch, 32'h1);
    hresetn = 1'b0;
    trip_req <= 1'b0;
    tick(2);
    chk({irq, ramp_halt, high_side_trip_flag, trip_hold_latch, hresp,
      hreadyout}, 32'h1);
    hresetn = 1'b1;
    ahb(1'b0, CTL_OFS_FILTER, 32'h0);
    chk(rd, {11'h000, CTL_CNT_RESET, 6'h00, CTL_DIV_RESET});
    end_of_test;
  end
endmodule
bind ctl_trip_latch ctl_trip_monitor ctl_trip_monitor_inst (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hwdata(hwdata),
  .hrdata(hrdata),
  .comp_in(comp_in),
  .pwm_period_sync_pulse(pwm_period_sync_pulse),
  .trip_hold_latch(trip_hold_latch),
  .high_side_trip_flag(high_side_trip_flag),
  .ramp_halt(ramp_halt),
  .irq(irq)
);
